// [common/mmd_map.vh]
// Address map, register offsets, strap fields and access kinds of the memory map decoder
`ifndef MMD_MAP_VH
`define MMD_MAP_VH
// Event transfer pointer area
`define MMD_PTR_BASE     16'hFCE0
`define MMD_PTR_LAST     16'hFCFE
// Register blocks and internal areas in segment 0
`define MMD_SREG_BASE     16'hFE00
`define MMD_SREG_LAST     16'hFFFF
`define MMD_SREG_BIT_BASE 16'hFF00
`define MMD_XREG_BASE     16'hF000
`define MMD_XREG_LAST     16'hF1FF
`define MMD_XREG_BIT_BASE 16'hF100
`define MMD_RAM_BASE     16'hFA00
`define MMD_RAM_LAST     16'hFDFF
`define MMD_RAM_BIT_BASE 16'hFD00
`define MMD_XP_BASE      16'hE000
`define MMD_XP_LAST      16'hE7FF
// Short offsets from here upward select the general registers
`define MMD_GPR_OFF      8'hF0
`define MMD_BITOFF_SPLIT 8'h80
// Access kinds on the CPU port
`define MMD_K_LONG       3'h0
`define MMD_K_INDIRECT   3'h1
`define MMD_K_SHORT      3'h2
`define MMD_K_BIT        3'h3
`define MMD_K_PTR        3'h4
`define MMD_K_XFER       3'h5
`define MMD_K_CODE       3'h6
// Target one-hot positions
`define MMD_T_RAM        0
`define MMD_T_SREG       1
`define MMD_T_XREG       2
`define MMD_T_XP         3
`define MMD_T_EXT        4
// Segmentation settings (upper address lines driven)
`define MMD_SEG_NONE     2'h0
`define MMD_SEG_A17      2'h1
`define MMD_SEG_A19      2'h2
`define MMD_SEG_A23      2'h3
// Bus mode field: bit 0 demultiplexed, bit 1 eight-bit data
`define MMD_BUS_MUX16    2'h0
// AXI4-Lite register byte offsets
`define MMD_REG_PAGE0    8'h00
`define MMD_REG_PAGE1    8'h04
`define MMD_REG_PAGE2    8'h08
`define MMD_REG_PAGE3    8'h0C
`define MMD_REG_CTX      8'h10
`define MMD_REG_CSEG     8'h14
`define MMD_REG_STRAP    8'h18
`define MMD_REG_STATUS   8'h1C
// Reset values and extend counter maximum
`define MMD_CTX_RESET    16'hFC00
`define MMD_PAGE_RESET   10'h000
`define MMD_XTND_MAX     3'h4
`endif

// [design/mmd_target_decode.v]
// Target selector: maps one 24-bit physical address onto exactly one target
`timescale 1ns/1ns
`include "mmd_map.vh"
module mmd_target_decode #(
  parameter [15:0] XP_BASE = `MMD_XP_BASE,
  parameter [15:0] XP_LAST = `MMD_XP_LAST
) (
  input  wire [23:0] phys,
  output reg  [4:0]  tgt
);
  wire        seg0 = (phys[23:16] == 8'h00);
  wire [15:0] low  = phys[15:0];

  // Priority chain yields one hot bit; anything unclaimed goes outside
  always @* begin
    tgt = 5'h00;
    if (seg0 && low >= `MMD_SREG_BASE) begin
      tgt[`MMD_T_SREG] = 1'b1;
    end else if (seg0 && low >= `MMD_RAM_BASE && low <= `MMD_RAM_LAST) begin
      tgt[`MMD_T_RAM] = 1'b1;
    end else if (seg0 && low >= `MMD_XREG_BASE && low <= `MMD_XREG_LAST) begin
      // Lower bound matters: the rest of segment 0 below it is external, except the XP window
      tgt[`MMD_T_XREG] = 1'b1;
    end else if (seg0 && low >= XP_BASE && low <= XP_LAST) begin
      tgt[`MMD_T_XP] = 1'b1;
    end else begin
      tgt[`MMD_T_EXT] = 1'b1;
    end
  end
endmodule

// [design/mmd_decoder.v]
// Memory map decoder: address forming, target routing, strap capture, AXI4-Lite registers
`timescale 1ns/1ns
`include "mmd_map.vh"
module mmd_decoder #(
  parameter [15:0] XP_BASE = `MMD_XP_BASE,
  parameter [15:0] XP_LAST = `MMD_XP_LAST
) (
  input  wire        aclk,
  input  wire        aresetn,
  // Strap pins sampled while reset is low
  input  wire        external_access_pin,
  input  wire [3:0]  address_data_lane_strap,
  // CPU access port
  input  wire        acc_valid,
  output wire        acc_ready,
  input  wire [2:0]  acc_kind,
  input  wire [15:0] acc_addr,
  input  wire        acc_write,
  input  wire        acc_byte,
  input  wire [15:0] acc_wdata,
  input  wire        cpu_data_wait,
  input  wire        xtnd_issue,
  input  wire [1:0]  xtnd_count,
  input  wire        instr_done,
  input  wire        seg_load,
  input  wire [7:0]  seg_value,
  // Decoded access
  output reg         out_valid_r,
  output reg  [4:0]  out_tgt_r,
  output reg  [23:0] out_phys_r,
  output reg         out_write_r,
  output reg  [1:0]  out_be_r,
  output reg  [15:0] out_wdata_r,
  output reg         out_bit_r,
  output reg  [3:0]  out_bitpos_r,
  output reg         out_fault_r,
  // External bus controller request
  output reg         xbus_req_valid_r,
  input  wire        xbus_req_ready,
  input  wire        xbus_done,
  output reg  [15:0] lane_addr_r,
  output reg  [7:0]  upper_addr_r,
  output reg  [1:0]  bus_mode_r,
  output reg  [1:0]  seg_mode_r,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  reg  [9:0]  page_r [0:3];
  reg  [15:0] ctx_r;
  reg  [7:0]  cseg_r;
  reg  [2:0]  xtnd_cnt_r;
  reg         ext_busy_r;
  reg         xpin_r;
  reg  [4:0]  strap_s1_r;
  reg  [4:0]  strap_s2_r;
  reg  [7:0]  aw_addr_r;
  reg         aw_got_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_got_r;
  reg  [23:0] phys_nxt;
  reg         bit_nxt;
  reg         fault_nxt;
  reg  [15:0] short_addr;
  reg  [31:0] rd_nxt;
  reg         rd_ok;
  reg         wr_ok;
  wire [4:0]  tgt_nxt;
  wire        ext_sel;
  wire        take;
  wire        xbus_issue;
  wire        wr_fire;
  wire        ext_mode;
  wire [7:0]  off;
  wire [15:0] gpr_addr;
  wire [9:0]  page_sel;
  wire        regblk;
  integer     i;

  assign off      = acc_addr[7:0];
  assign ext_mode = (xtnd_cnt_r != 3'h0);
  assign gpr_addr = ctx_r + {11'h000, off[3:0], 1'b0};
  assign page_sel = page_r[acc_addr[15:14]];

  // Short register and bit offsets turned into segment-0 word addresses
  always @* begin
    short_addr = 16'h0000;
    if (off >= `MMD_GPR_OFF) begin
      short_addr = gpr_addr;
    end else if (acc_kind == `MMD_K_BIT && off < `MMD_BITOFF_SPLIT) begin
      short_addr = `MMD_RAM_BIT_BASE + {8'h00, off[6:0], 1'b0};
    end else if (acc_kind == `MMD_K_BIT) begin
      // Bit offsets reach only the upper half of the selected block
      short_addr = (ext_mode ? `MMD_XREG_BIT_BASE : `MMD_SREG_BIT_BASE)
                   + {8'h00, off[6:0], 1'b0};
    end else begin
      // Offset counts words, so only even addresses, never a high byte alone
      short_addr = (ext_mode ? `MMD_XREG_BASE : `MMD_SREG_BASE)
                   + {7'h00, off, 1'b0};
    end
  end

  // Physical address per access kind
  always @* begin
    phys_nxt  = 24'h000000;
    bit_nxt   = 1'b0;
    fault_nxt = 1'b0;
    case (acc_kind)
      `MMD_K_LONG, `MMD_K_INDIRECT: begin
        phys_nxt  = {page_sel, acc_addr[13:0]};
        fault_nxt = !acc_byte && acc_addr[0];
      end
      `MMD_K_SHORT: begin
        phys_nxt = {8'h00, short_addr};
      end
      `MMD_K_BIT: begin
        phys_nxt = {8'h00, short_addr};
        bit_nxt  = 1'b1;
      end
      `MMD_K_PTR: begin
        // Channel in bits 3..1, bit 0 picks destination over source
        phys_nxt = {8'h00, `MMD_PTR_BASE + {11'h000, acc_addr[3:0], 1'b0}};
      end
      `MMD_K_XFER: begin
        phys_nxt  = {8'h00, acc_addr};
        fault_nxt = !acc_byte && acc_addr[0];
      end
      `MMD_K_CODE: begin
        // Low 16 bits wrap inside the segment, segment never carries
        phys_nxt  = {cseg_r, acc_addr};
        fault_nxt = acc_addr[0];
      end
      default: begin
        fault_nxt = 1'b1;
      end
    endcase
  end

  mmd_target_decode #(
    .XP_BASE (XP_BASE),
    .XP_LAST (XP_LAST)
  ) u_tgt (
    .phys (phys_nxt),
    .tgt  (tgt_nxt)
  );

  assign ext_sel = tgt_nxt[`MMD_T_EXT];
  assign regblk  = tgt_nxt[`MMD_T_SREG] || tgt_nxt[`MMD_T_XREG];
  // Stall only when the bus controller is busy and its result or lane is needed
  assign acc_ready = !(ext_busy_r && (cpu_data_wait || (acc_valid && ext_sel)));
  assign take      = acc_valid && acc_ready;
  assign xbus_issue = take && ext_sel && !fault_nxt;

  // Decoded access register, one pulse per accepted access
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_r  <= 1'b0;
      out_tgt_r    <= 5'h00;
      out_phys_r   <= 24'h000000;
      out_write_r  <= 1'b0;
      out_be_r     <= 2'h0;
      out_wdata_r  <= 16'h0000;
      out_bit_r    <= 1'b0;
      out_bitpos_r <= 4'h0;
      out_fault_r  <= 1'b0;
      lane_addr_r  <= 16'h0000;
      upper_addr_r <= 8'h00;
    end else begin
      out_valid_r <= take;
      if (take) begin
        out_tgt_r    <= tgt_nxt;
        out_phys_r   <= phys_nxt;
        out_write_r  <= acc_write;
        out_bit_r    <= bit_nxt;
        out_bitpos_r <= acc_addr[11:8];
        out_fault_r  <= fault_nxt;
        if (!acc_byte) begin
          out_be_r    <= 2'h3;
          out_wdata_r <= acc_wdata;
        end else if (acc_write && regblk) begin
          // Whole word written so the other byte is forced to zero
          out_be_r    <= 2'h3;
          out_wdata_r <= phys_nxt[0] ? {acc_wdata[7:0], 8'h00}
                                     : {8'h00, acc_wdata[7:0]};
        end else begin
          out_be_r    <= phys_nxt[0] ? 2'h2 : 2'h1;
          out_wdata_r <= phys_nxt[0] ? {acc_wdata[7:0], 8'h00}
                                     : {8'h00, acc_wdata[7:0]};
        end
        if (xbus_issue) begin
          lane_addr_r <= phys_nxt[15:0];
          case (seg_mode_r)
            `MMD_SEG_A17: upper_addr_r <= {6'h00, phys_nxt[17:16]};
            `MMD_SEG_A19: upper_addr_r <= {4'h0, phys_nxt[19:16]};
            `MMD_SEG_A23: upper_addr_r <= phys_nxt[23:16];
            default:      upper_addr_r <= 8'h00;
          endcase
        end
      end
    end
  end

  // External request handshake and busy tracking; done ends the busy phase
  always @(posedge aclk) begin
    if (!aresetn) begin
      xbus_req_valid_r <= 1'b0;
      ext_busy_r       <= 1'b0;
    end else begin
      if (xbus_issue) begin
        xbus_req_valid_r <= 1'b1;
      end else if (xbus_req_ready) begin
        xbus_req_valid_r <= 1'b0;
      end
      if (xbus_issue) begin
        ext_busy_r <= 1'b1;
      end else if (xbus_done) begin
        ext_busy_r <= 1'b0;
      end
    end
  end

  // Extended addressing window; a new extend instruction wins over countdown
  always @(posedge aclk) begin
    if (!aresetn) begin
      xtnd_cnt_r <= 3'h0;
    end else if (xtnd_issue) begin
      xtnd_cnt_r <= {1'b0, xtnd_count} + 3'h1;
    end else if (instr_done && ext_mode) begin
      xtnd_cnt_r <= xtnd_cnt_r - 3'h1;
    end
  end

  // Code segment pointer changes only on inter-segment branches
  always @(posedge aclk) begin
    if (!aresetn) begin
      cseg_r <= 8'h00;
    end else if (seg_load) begin
      cseg_r <= seg_value;
    end
  end

  // Strap synchroniser; pins are asynchronous so two stages before use
  always @(posedge aclk) begin
    strap_s1_r <= {external_access_pin, address_data_lane_strap};
    strap_s2_r <= strap_s1_r;
  end

  // Straps follow the pins throughout reset and freeze at its release
  always @(posedge aclk) begin
    if (!aresetn) begin
      xpin_r     <= strap_s2_r[4];
      seg_mode_r <= strap_s2_r[3:2];
      bus_mode_r <= strap_s2_r[1:0];
    end
  end

  // AXI4-Lite write channels, address and data accepted in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign wr_fire       = aw_got_r && w_got_r && !s_axi_bvalid;

  always @* begin
    case (aw_addr_r)
      `MMD_REG_PAGE0, `MMD_REG_PAGE1, `MMD_REG_PAGE2, `MMD_REG_PAGE3,
      `MMD_REG_CTX: wr_ok = 1'b1;
      default:      wr_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctx_r        <= `MMD_CTX_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        page_r[i] <= `MMD_PAGE_RESET;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
        if (aw_addr_r == `MMD_REG_CTX) begin
          // Bank base kept word aligned
          if (w_strb_r[0]) ctx_r[7:0]  <= {w_data_r[7:1], 1'b0};
          if (w_strb_r[1]) ctx_r[15:8] <= w_data_r[15:8];
        end else if (wr_ok) begin
          if (w_strb_r[0]) page_r[aw_addr_r[3:2]][7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) page_r[aw_addr_r[3:2]][9:8] <= w_data_r[9:8];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; status words show decoder state
  always @* begin
    rd_nxt = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `MMD_REG_PAGE0:  rd_nxt = {22'h000000, page_r[0]};
      `MMD_REG_PAGE1:  rd_nxt = {22'h000000, page_r[1]};
      `MMD_REG_PAGE2:  rd_nxt = {22'h000000, page_r[2]};
      `MMD_REG_PAGE3:  rd_nxt = {22'h000000, page_r[3]};
      `MMD_REG_CTX:    rd_nxt = {16'h0000, ctx_r};
      `MMD_REG_CSEG:   rd_nxt = {24'h000000, cseg_r};
      `MMD_REG_STRAP:  rd_nxt = {27'h0000000, xpin_r, seg_mode_r, bus_mode_r};
      `MMD_REG_STATUS: rd_nxt = {26'h0000000, xbus_req_valid_r, ext_busy_r, ext_mode,
                                 xtnd_cnt_r};
      default:         rd_ok  = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_nxt;
      s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [test/mmd_decoder_sva.sv]
// Concurrent checks on the memory map decoder ports
`timescale 1ns/1ns
`include "mmd_map.vh"
module mmd_decoder_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire        acc_valid,
  input wire        acc_ready,
  input wire [2:0]  acc_kind,
  input wire        acc_write,
  input wire        acc_byte,
  input wire        cpu_data_wait,
  input wire        out_valid_r,
  input wire [4:0]  out_tgt_r,
  input wire [23:0] out_phys_r,
  input wire [1:0]  out_be_r,
  input wire [15:0] out_wdata_r,
  input wire        out_bit_r,
  input wire        out_fault_r,
  input wire        xbus_req_valid_r,
  input wire        xbus_req_ready,
  input wire [15:0] lane_addr_r,
  input wire [7:0]  upper_addr_r,
  input wire [1:0]  bus_mode_r,
  input wire [1:0]  seg_mode_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Good external answer and the upper lines each segmentation setting drives
  wire       ext_ok = out_valid_r && out_tgt_r[`MMD_T_EXT] && !out_fault_r;
  wire [7:0] seg_mask = (seg_mode_r == 2'h0) ? 8'h00 : (seg_mode_r == 2'h1) ? 8'h03 :
                        (seg_mode_r == 2'h2) ? 8'h0F : 8'hFF;
  sequence s_take;
    acc_valid && acc_ready;
  endsequence
  sequence s_reg_byte;
    acc_valid && acc_ready && acc_write && acc_byte ##1 (out_tgt_r[1] || out_tgt_r[2]);
  endsequence
  sequence s_xfer;
    acc_valid && acc_ready && acc_kind == `MMD_K_XFER ##1 !out_fault_r;
  endsequence
  property p_answer;
    s_take |=> out_valid_r && $onehot(out_tgt_r);
  endproperty
  a_answer: assert property (p_answer) else $error("no single target answer");
  property p_ext_req;
    ext_ok |-> xbus_req_valid_r;
  endproperty
  a_ext_req: assert property (p_ext_req) else $error("external access not forwarded");
  property p_req_hold;
    xbus_req_valid_r && !xbus_req_ready |=> xbus_req_valid_r;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request dropped");
  property p_stall;
    xbus_req_valid_r && cpu_data_wait |-> !acc_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("cpu not held");
  property p_even;
    ext_ok && out_be_r == 2'b11 |-> !out_phys_r[0];
  endproperty
  a_even: assert property (p_even) else $error("odd external word");
  property p_lanes;
    ext_ok |-> lane_addr_r == out_phys_r[15:0] && upper_addr_r == (out_phys_r[23:16] & seg_mask);
  endproperty
  a_lanes: assert property (p_lanes) else $error("address lanes wrong");
  property p_no_bit_ext;
    out_valid_r && out_bit_r |-> !out_tgt_r[`MMD_T_EXT];
  endproperty
  a_no_bit_ext: assert property (p_no_bit_ext) else $error("bit access external");
  property p_reg_byte;
    s_reg_byte |-> out_be_r == 2'b11 && (out_wdata_r[15:8] == 8'h00 || out_wdata_r[7:0] == 8'h00);
  endproperty
  a_reg_byte: assert property (p_reg_byte) else $error("other byte kept");
  property p_xfer_seg0;
    s_xfer |-> out_phys_r[23:16] == 8'h00;
  endproperty
  a_xfer_seg0: assert property (p_xfer_seg0) else $error("transfer left segment 0");
  property p_straps;
    $past(aresetn) |-> $stable(seg_mode_r) && $stable(bus_mode_r);
  endproperty
  a_straps: assert property (p_straps) else $error("straps changed after reset");
endmodule
bind mmd_decoder mmd_decoder_sva u_sva (.*);

// [test/mmd_ebc_model.sv]
// External bus controller stand-in with a settable answer lag
`timescale 1ns/1ns
module mmd_xbus_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       req_valid,
  input  wire [3:0] lag,
  output reg        ready_r,
  output reg        done_r
);
  reg [3:0] cnt_r;
  reg       busy_r;
  // Take the request lag+1 cycles after seeing it, finish lag+1 cycles later; a slow lag forces stalls
  always @(posedge aclk) begin
    ready_r <= 1'b0;
    done_r <= 1'b0;
    if (!aresetn) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
    end else if (busy_r || (req_valid && !ready_r)) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == lag) begin
        cnt_r <= 4'h0;
        busy_r <= !busy_r;
        ready_r <= !busy_r;
        done_r <= busy_r;
      end
    end
  end
endmodule

// [test/memory_map_address_decoder_test.sv]
// Self-checking bench of the memory map decoder
`timescale 1ns/1ns
`include "mmd_map.vh"
module memory_map_address_decoder_test;
  typedef struct packed {logic [2:0] k; logic [15:0] a; logic [4:0] t; logic [23:0] p; logic f;}
    mmd_row_t;
  // Ordinary accesses; pages 0 and 3 hold 5 and 3, context at reset value
  localparam mmd_row_t ROWS [12] = '{
    '{`MMD_K_LONG, 16'h1234, 5'h10, 24'h015234, 1'b0},
    '{`MMD_K_LONG, 16'hFE10, 5'h02, 24'h00FE10, 1'b0},
    '{`MMD_K_SHORT, 16'h0008, 5'h02, 24'h00FE10, 1'b0},
    '{`MMD_K_SHORT, 16'h00F2, 5'h01, 24'h00FC04, 1'b0},
    '{`MMD_K_BIT, 16'h0305, 5'h01, 24'h00FD0A, 1'b0},
    '{`MMD_K_BIT, 16'h0385, 5'h02, 24'h00FF0A, 1'b0},
    '{`MMD_K_PTR, 16'h0005, 5'h01, 24'h00FCEA, 1'b0},
    '{`MMD_K_XFER, 16'h3000, 5'h10, 24'h003000, 1'b0},
    '{`MMD_K_INDIRECT, 16'hF100, 5'h04, 24'h00F100, 1'b0},
    '{`MMD_K_LONG, 16'hE002, 5'h08, 24'h00E002, 1'b0},
    '{`MMD_K_LONG, 16'h1235, 5'h00, 24'h000000, 1'b1},
    '{`MMD_K_CODE, 16'h0100, 5'h10, 24'h000100, 1'b0}};
  logic        aclk = 0, aresetn = 0, external_access_pin = 0, acc_valid = 0, acc_write = 0;
  logic        acc_byte = 0, cpu_data_wait = 0, xtnd_issue = 0, instr_done = 0, seg_load = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0;
  logic [1:0]  xtnd_count = 0;
  logic [2:0]  acc_kind = 0;
  logic [3:0]  address_data_lane_strap = 0, s_axi_wstrb = 4'hF, lag = 4'h1;
  logic [7:0]  seg_value = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [15:0] acc_addr = 0, acc_wdata = 16'h00AB;
  logic [31:0] s_axi_wdata = 0;
  wire         acc_ready, out_valid_r, out_write_r, out_bit_r, out_fault_r, xbus_req_valid_r;
  wire         xbus_req_ready, xbus_done, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire [1:0]   out_be_r, bus_mode_r, seg_mode_r, s_axi_bresp, s_axi_rresp;
  wire [3:0]   out_bitpos_r;
  wire [4:0]   out_tgt_r;
  wire [7:0]   upper_addr_r;
  wire [15:0]  out_wdata_r, lane_addr_r;
  wire [23:0]  out_phys_r;
  wire [31:0]  s_axi_rdata;
  int          errors = 0, total_checks = 0, n;
  mmd_decoder dut (.*);
  mmd_xbus_model u_xbus (.aclk(aclk), .aresetn(aresetn), .req_valid(xbus_req_valid_r),
                         .lag(lag), .ready_r(xbus_req_ready), .done_r(xbus_done));
  // Free-running 50 MHz clock
  always #10 aclk = ~aclk;
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      total_checks++;
      if (g !== e) begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task exp(input logic [4:0] t, input logic [23:0] p);
    begin
      chk(out_tgt_r, t);
      chk(out_phys_r, p);
    end
  endtask
  // CPU access: hold until taken, then look at the answer one cycle on
  task acc(input logic [2:0] k, input logic [15:0] a, input logic w, input logic by, output int c);
    logic r;
    begin
      @(posedge aclk);
      acc_kind <= k;
      acc_addr <= a;
      acc_write <= w;
      acc_byte <= by;
      acc_valid <= 1'b1;
      r = 0;
      c = 0;
      while (!r) begin
        @(negedge aclk);
        r = acc_ready;
        c++;
        @(posedge aclk);
      end
      acc_valid <= 1'b0;
      @(negedge aclk);
      chk(out_valid_r, 1);
    end
  endtask
  // AXI4-Lite access; sampling at the falling edge shows what the next rising edge takes
  task ax(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, wr, ar, b;
    logic [1:0] rs;
    logic [31:0] rd;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      s_axi_bready <= w;
      s_axi_rready <= !w;
      b = 0;
      while (!b) begin
        @(negedge aclk);
        aw = s_axi_awready;
        wr = s_axi_wready;
        ar = s_axi_arready;
        b = w ? s_axi_bvalid : s_axi_rvalid;
        rs = w ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        @(posedge aclk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (wr) s_axi_wvalid <= 1'b0;
        if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      chk(rs, r);
      if (!w) chk(rd, d);
    end
  endtask
  // Cuts a hang short
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(bus_mode_r, `MMD_BUS_MUX16);
    chk(seg_mode_r, `MMD_SEG_NONE);
    ax(0, `MMD_REG_CTX, 32'hFC00, 2'h0);
    ax(1, `MMD_REG_PAGE0, 32'h5, 2'h0);
    ax(1, `MMD_REG_PAGE3, 32'h3, 2'h0);
    ax(0, `MMD_REG_PAGE3, 32'h3, 2'h0);
    ax(0, 8'h20, 32'h0, 2'h2);
    ax(1, `MMD_REG_CSEG, 32'h1, 2'h2);
    foreach (ROWS[i]) begin
      acc(ROWS[i].k, ROWS[i].a, 1'b0, 1'b0, n);
      chk(out_fault_r, ROWS[i].f);
      if (!ROWS[i].f) exp(ROWS[i].t, ROWS[i].p);
      chk(out_bit_r, ROWS[i].k == `MMD_K_BIT);
      chk(out_write_r, 0);
      if (ROWS[i].k == `MMD_K_BIT) chk(out_bitpos_r, ROWS[i].a[11:8]);
    end
    // Slow far side: internal work runs on, data wait and a second request stall
    lag <= 4'h8;
    acc(`MMD_K_LONG, 16'h1234, 1'b0, 1'b0, n);
    acc(`MMD_K_SHORT, 16'h0008, 1'b1, 1'b1, n);
    chk(n, 1);
    chk({out_be_r, out_wdata_r}, 18'h300AB);
    chk(out_write_r, 1);
    @(posedge aclk);
    cpu_data_wait <= 1'b1;
    @(negedge aclk);
    chk(acc_ready, 0);
    @(posedge aclk);
    cpu_data_wait <= 1'b0;
    acc(`MMD_K_LONG, 16'h1234, 1'b0, 1'b0, n);
    chk(n > 1, 1);
    // Extend for two instructions
    @(posedge aclk);
    xtnd_issue <= 1'b1;
    xtnd_count <= 2'h1;
    @(posedge aclk);
    xtnd_issue <= 1'b0;
    acc(`MMD_K_SHORT, 16'h0008, 1'b0, 1'b0, n);
    exp(5'h04, 24'h00F010);
    acc(`MMD_K_SHORT, 16'h00F2, 1'b0, 1'b0, n);
    exp(5'h01, 24'h00FC04);
    repeat (2) begin
      acc(`MMD_K_BIT, 16'h0385, 1'b0, 1'b0, n);
      exp(5'h04, 24'h00F10A);
      @(posedge aclk);
      instr_done <= 1'b1;
      @(posedge aclk);
      instr_done <= 1'b0;
    end
    acc(`MMD_K_SHORT, 16'h0008, 1'b0, 1'b0, n);
    exp(5'h02, 24'h00FE10);
    // Segment load; fetch wraps inside the segment
    @(posedge aclk);
    seg_load <= 1'b1;
    seg_value <= 8'h12;
    @(posedge aclk);
    seg_load <= 1'b0;
    acc(`MMD_K_CODE, 16'hFFFE, 1'b0, 1'b0, n);
    exp(5'h10, 24'h12FFFE);
    acc(`MMD_K_CODE, 16'h0000, 1'b0, 1'b0, n);
    exp(5'h10, 24'h120000);
    ax(0, `MMD_REG_CSEG, 32'h12, 2'h0);
    // Second reset with other straps
    @(posedge aclk);
    address_data_lane_strap <= 4'b0101;
    external_access_pin <= 1'b1;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({seg_mode_r, bus_mode_r}, 4'b0101);
    ax(0, `MMD_REG_STRAP, 32'h15, 2'h0);
    ax(1, `MMD_REG_PAGE0, 32'h5, 2'h0);
    acc(`MMD_K_LONG, 16'h1234, 1'b0, 1'b0, n);
    chk({upper_addr_r, lane_addr_r}, 24'h015234);
    report_and_stop;
  end
endmodule
